// File: rtl/lgpdt_core.sv
/*
  LED gray-level PWM and current-trim core: serial shift register, trim and
  gray-level latches, status packet, gray-level counter and sink enables.
  Assumes every link pin is asynchronous and is sampled by the 200 MHz clk;
  the analog side supplies per-channel low-voltage and a single over-temperature flag.
*/
`timescale 1ns/100ps
module lgpdt_core
  import lgpdt_pkg::*;
#(
  parameter int OPEN_DELAY_CYC = OPEN_DETECT_CYC,
  parameter int FIFO_DEPTH     = 16
)
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // Serial link pins
  input  wire logic                serialIn,
  input  wire logic                shiftClk,
  input  wire logic                latchStrobe,
  input  wire logic                modeSel,
  input  wire logic                blank,
  input  wire logic                pwmCountClk,
  output logic                     serialOut,
  // Error pin, open drain
  output logic                     errorOut_n,
  output logic                     errorOutEn,
  // Analog side
  input  wire logic [CHANNELS-1:0] lowVoltage,
  input  wire logic                overTemp,
  output logic [CHANNELS-1:0]      sinkChannel,
  output logic [TRIM_LEN-1:0]      currentTrim
);

  initial
  begin
    if (OPEN_DELAY_CYC < 1 || OPEN_DELAY_CYC > 1023)
      $error("lgpdt_core: OPEN_DELAY_CYC out of range");
  end

  // ==========================================================================
  // Pin synchronisation
  lgpdt_link_s link, linkPrev_reg;
  logic [5:0]  linkRaw, linkLvl;

  assign linkRaw = {serialIn, shiftClk, latchStrobe, modeSel, blank, pwmCountClk};

  lgpdt_sync #(.WIDTH(6)) u_sync (
    .clk      (clk),
    .rst      (rst),
    .pinIn    (linkRaw),
    .levelOut (linkLvl)
  );

  assign link = lgpdt_link_s'(linkLvl);

  logic [CHANNELS:0] senseLvl;
  lgpdt_sync #(.WIDTH(CHANNELS+1)) u_sense (
    .clk      (clk),
    .rst      (rst),
    .pinIn    ({overTemp, lowVoltage}),
    .levelOut (senseLvl)
  );

  // Edge detection on filtered levels
  logic shiftRise, strobeRise, strobeFall, blankFall, pwmRise;
  always_comb
  begin
    shiftRise  = link.shiftClk && !linkPrev_reg.shiftClk;
    strobeRise = link.latchStrobe && !linkPrev_reg.latchStrobe;
    strobeFall = !link.latchStrobe && linkPrev_reg.latchStrobe;
    blankFall  = !link.blank && linkPrev_reg.blank;
    pwmRise    = link.pwmCountClk && !linkPrev_reg.pwmCountClk;
  end

  always_ff @(posedge clk)
  begin
    if (rst) linkPrev_reg <= '0;
    else     linkPrev_reg <= link;
  end

  // ==========================================================================
  // Serial bit FIFO: decouples sampled bits from the shift register update
  logic fifoInReady, fifoOutValid, fifoOutData, shiftTake;

  lgpdt_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk      (clk),
    .rst      (rst),
    .inValid  (shiftRise),
    .inReady  (fifoInReady),
    .inData   (link.serialIn),
    .outValid (fifoOutValid),
    .outReady (shiftTake),
    .outData  (fifoOutData)
  );

  // Shift stalls while a strobe is high so latch and shift never collide
  assign shiftTake = !link.latchStrobe;

  // ==========================================================================
  // Shift register, latches and status packet
  lgpdt_shift_t shift_reg, shift_next;
  lgpdt_trim_t  trim_reg, trim_next;
  lgpdt_gray_t  gray_reg, gray_next;
  logic [CHANNELS-1:0] openCap_reg, openCap_next;
  logic [CHANNELS-1:0] openFlag_reg, openFlag_next;
  logic         pendStatus_reg, pendStatus_next;
  logic         serialOut_reg, serialOut_next;

  // Status packet assembly from captured flags and trim readback
  function automatic lgpdt_shift_t statusPacket(input logic [CHANNELS-1:0] op,
                                                input logic tf,
                                                input lgpdt_trim_t tr);
    lgpdt_shift_t p;
    p = '0;
    p[STAT_OPEN_LSB +: CHANNELS]     = op;
    p[STAT_TEMP_BIT]                 = tf;
    p[STAT_TRIM_MSB:STAT_TRIM_LSB]   = tr;
    return p;
  endfunction

  always_comb
  begin
    shift_next      = shift_reg;
    trim_next       = trim_reg;
    gray_next       = gray_reg;
    openCap_next    = openCap_reg;
    pendStatus_next = 1'b0;
    // Bit enters at LSB, older bits move toward MSB; MSB-first data
    if (fifoOutValid && shiftTake)
      shift_next = {shift_reg[GRAY_LEN-2:0], fifoOutData};
    // Trim latch is level sensitive and ignores blank
    if (link.mode && link.latchStrobe)
      trim_next = shift_reg[TRIM_LEN-1:0];
    // Rising strobe in gray mode updates all channels at once
    if (!link.mode && strobeRise)
    begin
      gray_next       = shift_reg;
      pendStatus_next = 1'b1;
    end
    // Open flags caught as the strobe returns low
    if (strobeFall)
      openCap_next = openFlag_reg;
    // One cycle after the gray update the status replaces the data
    if (pendStatus_reg)
      shift_next = statusPacket(openCap_next, senseLvl[CHANNELS], trim_reg);
    // Serial out taps the active length end
    serialOut_next = link.mode ? shift_next[TRIM_LEN-1] : shift_next[GRAY_LEN-1];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      shift_reg      <= '0;
      trim_reg       <= '0;
      gray_reg       <= '0;
      openCap_reg    <= '0;
      pendStatus_reg <= 1'b0;
      serialOut_reg  <= 1'b0;
    end
    else
    begin
      shift_reg      <= shift_next;
      trim_reg       <= trim_next;
      gray_reg       <= gray_next;
      openCap_reg    <= openCap_next;
      pendStatus_reg <= pendStatus_next;
      serialOut_reg  <= serialOut_next;
    end
  end

  // ==========================================================================
  // Gray-level counter state machine
  lgpdt_pwm_e     pwm_reg, pwm_next;
  logic [11:0]    count_reg, count_next;
  logic [CHANNELS-1:0] on_reg, on_next;

  function automatic logic [GRAY_BITS-1:0] grayOf(input lgpdt_gray_t g, input int ch);
    return g[ch*GRAY_BITS +: GRAY_BITS];
  endfunction

  always_comb
  begin
    pwm_next   = pwm_reg;
    count_next = count_reg;
    on_next    = on_reg;
    unique case (pwm_reg)
      PWM_IDLE:
      begin
        if (pwmRise)
        begin
          count_next = count_reg + 12'h001;
          pwm_next   = PWM_RUN;
          for (int c = 0; c < CHANNELS; c++)
            on_next[c] = (grayOf(gray_reg, c) != 12'h000);
        end
      end
      PWM_RUN:
      begin
        if (pwmRise)
        begin
          count_next = count_reg + 12'h001;
          for (int c = 0; c < CHANNELS; c++)
            if (grayOf(gray_reg, c) == count_reg) on_next[c] = 1'b0;
          if (count_next == COUNT_MAX)
          begin
            pwm_next = PWM_DONE;
            on_next  = '0;
          end
        end
      end
      PWM_DONE:
      begin
        on_next = '0;
      end
    endcase
    // Blank wins over everything and clears the counter at once
    if (link.blank)
    begin
      pwm_next   = PWM_IDLE;
      count_next = 12'h000;
      on_next    = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pwm_reg   <= PWM_IDLE;
      count_reg <= 12'h000;
      on_reg    <= '0;
    end
    else
    begin
      pwm_reg   <= pwm_next;
      count_reg <= count_next;
      on_reg    <= on_next;
    end
  end

  // ==========================================================================
  // Open detection: per-channel timer runs while sink on and voltage low
  logic [9:0]          openTmr_reg [CHANNELS];
  logic [9:0]          openTmr_next [CHANNELS];
  logic                errN_reg, errN_next;

  always_comb
  begin
    for (int c = 0; c < CHANNELS; c++)
    begin
      openTmr_next[c]  = 10'h000;
      openFlag_next[c] = 1'b0;
      if (on_reg[c] && !link.blank && senseLvl[c])
      begin
        openTmr_next[c]  = (openTmr_reg[c] == 10'(OPEN_DELAY_CYC)) ?
                           openTmr_reg[c] : openTmr_reg[c] + 10'h001;
        openFlag_next[c] = (openTmr_reg[c] == 10'(OPEN_DELAY_CYC));
      end
    end
    // Open flags are masked by blank, overtemp is not
    errN_next = !(senseLvl[CHANNELS] || (|openFlag_reg && !link.blank));
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int c = 0; c < CHANNELS; c++) openTmr_reg[c] <= 10'h000;
      openFlag_reg <= '0;
      errN_reg     <= 1'b1;
    end
    else
    begin
      openTmr_reg  <= openTmr_next;
      openFlag_reg <= openFlag_next;
      errN_reg     <= errN_next;
    end
  end

  // ==========================================================================
  // Outputs: blank gating applied before the output flop
  logic [CHANNELS-1:0] sink_reg;
  always_ff @(posedge clk)
  begin
    if (rst) sink_reg <= '0;
    else     sink_reg <= link.blank ? '0 : on_next;
  end

  assign sinkChannel = sink_reg;
  assign currentTrim = trim_reg;
  assign serialOut   = serialOut_reg;
  assign errorOut_n  = 1'b0;
  assign errorOutEn  = !errN_reg;   // Open drain: drive low only on error

  // ==========================================================================
  // Assertions
  blank_clears_a: assert property (@(posedge clk) disable iff (rst)
    link.blank |=> (count_reg == 12'h000) && (sink_reg == '0))
    else $error("blank did not clear counter and sinks");
  count_stops_a: assert property (@(posedge clk) disable iff (rst)
    (pwm_reg == PWM_DONE) && !link.blank |=> $stable(count_reg) && on_reg == '0)
    else $error("counter moved after reaching the end");
  gray_latch_a: assert property (@(posedge clk) disable iff (rst)
    (!link.mode && strobeRise) |=> gray_reg == $past(shift_reg))
    else $error("gray register not loaded on strobe rise");
  status_load_a: assert property (@(posedge clk) disable iff (rst)
    (!link.mode && strobeRise) |=> ##1 shift_reg[STAT_TRIM_MSB:STAT_TRIM_LSB] == trim_reg)
    else $error("status packet not loaded after gray update");
  trim_follow_a: assert property (@(posedge clk) disable iff (rst)
    (link.mode && link.latchStrobe) |=> trim_reg == $past(shift_reg[TRIM_LEN-1:0]))
    else $error("trim latch not transparent");
  trim_hold_a: assert property (@(posedge clk) disable iff (rst)
    !link.latchStrobe |=> $stable(trim_reg))
    else $error("trim changed with strobe low");
  shift_in_a: assert property (@(posedge clk) disable iff (rst)
    (fifoOutValid && shiftTake && !pendStatus_reg) |=> shift_reg[0] == $past(fifoOutData))
    else $error("serial bit not shifted in");
  serial_tap_a: assert property (@(posedge clk) disable iff (rst)
    !link.mode |=> serialOut_reg == shift_reg[GRAY_LEN-1])
    else $error("serial out not at register end");
  error_temp_a: assert property (@(posedge clk) disable iff (rst)
    senseLvl[CHANNELS] |=> errorOutEn)
    else $error("overtemp did not drive error");
  open_capture_a: assert property (@(posedge clk) disable iff (rst)
    strobeFall |=> openCap_reg == $past(openFlag_reg))
    else $error("open flags not captured on strobe fall");
  fifo_room_a: assert property (@(posedge clk) disable iff (rst)
    shiftRise |-> fifoInReady)
    else $error("serial bit arrived with the bit queue full");

  cover_gray_load_c: cover property (@(posedge clk) !link.mode && strobeRise);
  cover_trim_load_c: cover property (@(posedge clk) link.mode && strobeFall);
  cover_pwm_done_c:  cover property (@(posedge clk) pwm_reg == PWM_DONE);
  cover_open_c:      cover property (@(posedge clk) |openFlag_reg);
  cover_blank_end_c: cover property (@(posedge clk) blankFall);

endmodule

// File: rtl/lgpdt_fifo.sv
/*
  Small flip-flop FIFO with valid/ready on both sides.
  Assumes one clock; a full FIFO drops ready so the source must stall.
*/
`timescale 1ns/100ps
module lgpdt_fifo
  import lgpdt_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Write side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Read side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("lgpdt_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
  logic [AW:0]      count_reg, count_next;
  logic             doWrite, doRead;

  // ==========================================================================
  // Pointer and occupancy update
  always_comb
  begin
    doWrite    = inValid && (count_reg != AW'(0) + (AW+1)'(DEPTH));
    doRead     = outReady && (count_reg != '0);
    wrPtr_next = doWrite ? wrPtr_reg + AW'(1) : wrPtr_reg;
    rdPtr_next = doRead ? rdPtr_reg + AW'(1) : rdPtr_reg;
    count_next = count_reg + (AW+1)'(doWrite) - (AW+1)'(doRead);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
      count_reg <= count_next;
    end
  end

  // Storage holds no reset: contents are qualified by count
  always_ff @(posedge clk)
  begin
    if (doWrite) mem_reg[wrPtr_reg] <= inData;
  end

  assign inReady  = (count_reg != (AW+1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign outData  = mem_reg[rdPtr_reg];

endmodule

// File: rtl/lgpdt_pkg.sv
/*
  Package for the LED gray-level PWM and current-trim core: widths, packet
  layout, mode and state codes, timing counts and the carrier structs.
  Assumes a 200 MHz system clock that samples every link pin.
*/
package lgpdt_pkg;

  // ==========================================================================
  // Geometry
  localparam int CHANNELS      = 16;
  localparam int GRAY_BITS     = 12;
  localparam int TRIM_BITS     = 6;
  localparam int GRAY_LEN      = 192;
  localparam int TRIM_LEN      = 96;
  localparam int TRIM_FULL     = 63;

  // ==========================================================================
  // Status packet layout
  localparam int STAT_OPEN_LSB = 0;
  localparam int STAT_TEMP_BIT = 16;
  localparam int STAT_TRIM_LSB = 24;
  localparam int STAT_TRIM_MSB = 119;

  // ==========================================================================
  // Counter and timing
  localparam logic [11:0] COUNT_MAX      = 12'hFFF;
  localparam int          CLK_PERIOD_PS  = 5000;
  localparam int          OPEN_DETECT_NS = 1000;
  localparam int          OPEN_DETECT_CYC =
    (OPEN_DETECT_NS * 1000) / CLK_PERIOD_PS;
  localparam int          SYNC_STAGES    = 3;

  // ==========================================================================
  // Types
  typedef logic [GRAY_LEN-1:0]          lgpdt_shift_t;
  typedef logic [TRIM_LEN-1:0]          lgpdt_trim_t;
  typedef logic [CHANNELS*GRAY_BITS-1:0] lgpdt_gray_t;

  typedef enum logic [1:0] {
    LGPDT_GRAY = 2'b01,
    LGPDT_TRIM = 2'b10
  } lgpdt_mode_e;

  typedef enum logic [2:0] {
    PWM_IDLE  = 3'b001,
    PWM_RUN   = 3'b010,
    PWM_DONE  = 3'b100
  } lgpdt_pwm_e;

  // Link pin group after synchronisation
  typedef struct packed {
    logic serialIn;
    logic shiftClk;
    logic latchStrobe;
    logic mode;
    logic blank;
    logic pwmCountClk;
  } lgpdt_link_s;

  // Analog-side status coming back to the logic
  typedef struct packed {
    logic [CHANNELS-1:0] lowVoltage;
    logic                overTemp;
  } lgpdt_sense_s;

endpackage

// File: rtl/lgpdt_sync.sv
/*
  Three-stage synchroniser with agreement filter for each link pin.
  Assumes pins are asynchronous to clk; output moves once stages 2 and 3 agree.
*/
`timescale 1ns/100ps
module lgpdt_sync
  import lgpdt_pkg::*;
#(
  parameter int WIDTH = 6
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Pins and filtered levels
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] levelOut
);

  initial
  begin
    if (WIDTH < 1) $error("lgpdt_sync: WIDTH must be positive");
  end

  logic [WIDTH-1:0] stage1_reg, stage2_reg, stage3_reg, level_reg;
  logic [WIDTH-1:0] level_next;

  // ==========================================================================
  // Filter: stage1 is only read by stage2, so no metastable value escapes
  always_comb
  begin
    level_next = level_reg;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (stage2_reg[i] == stage3_reg[i]) level_next[i] = stage3_reg[i];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
      level_reg  <= '0;
    end
    else
    begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      level_reg  <= level_next;
    end
  end

  assign levelOut = level_reg;

endmodule

// File: sim/led_gray_pwm_dot_trim_core_test.sv
/*
  Self-checking bench for the LED gray-level PWM and trim core.
  Assumes the controller model drives the link pins; the bench drives
  reset and the analog sense inputs.
*/
`timescale 1ns/100ps
module led_gray_pwm_dot_trim_core_test
  import lgpdt_pkg::*;
;
  localparam lgpdt_trim_t   TRIM_VAL = 96'hFEDCBA987654321000FF0F3C;
  localparam lgpdt_shift_t  GRAY_MID = {16{12'h800}};
  localparam logic [15:0]   OPEN_PAT = 16'hA5C3;

  logic                clk;
  logic                rst;
  logic [CHANNELS-1:0] lowVoltage;
  logic                overTemp;
  logic                serialIn;
  logic                shiftClk;
  logic                latchStrobe;
  logic                modeSel;
  logic                blank;
  logic                pwmCountClk;
  logic                serialOut;
  logic                errorOutEn;
  logic                errorOut_n;
  logic [CHANNELS-1:0] openLed;
  logic [CHANNELS-1:0] sinkChannel;
  logic [TRIM_LEN-1:0] currentTrim;
  int                  fail_count;
  int                  cmp_count;
  int                  pulses;

  // ==========================================================================
  // Design and controller model; short open-detect delay keeps runs brief
  lgpdt_core #(.OPEN_DELAY_CYC(4), .FIFO_DEPTH(16)) u_lgpdt_core (
    .clk(clk), .rst(rst), .serialIn(serialIn), .shiftClk(shiftClk),
    .latchStrobe(latchStrobe), .modeSel(modeSel), .blank(blank),
    .pwmCountClk(pwmCountClk), .serialOut(serialOut), .errorOut_n(errorOut_n),
    .errorOutEn(errorOutEn), .lowVoltage(lowVoltage), .overTemp(overTemp),
    .sinkChannel(sinkChannel), .currentTrim(currentTrim));

  lgpdt_ctrl_model u_lgpdt_ctrl_model (
    .serialOut(serialOut), .serialIn(serialIn), .shiftClk(shiftClk),
    .latchStrobe(latchStrobe), .modeSel(modeSel), .blank(blank),
    .pwmCountClk(pwmCountClk));

  // Open LED model: the sink pin only sags while its sink is switched on
  assign lowVoltage = sinkChannel & openLed;

  // ==========================================================================
  // Clock, helpers and verdict
  always #2.5 clk = ~clk;

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input string what, input logic [191:0] seen,
                       input logic [191:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Latch a full gray packet
  task automatic loadGray(input lgpdt_shift_t d);
    u_lgpdt_ctrl_model.sendBits(d, GRAY_LEN);
    u_lgpdt_ctrl_model.strobe();
  endtask

  // Channel n holds n, channel 15 holds the top count
  function automatic lgpdt_shift_t pwmGray();
    for (int n = 0; n < CHANNELS; n++)
      pwmGray[n*GRAY_BITS +: GRAY_BITS] = (n == 15) ? COUNT_MAX : 12'(n);
  endfunction

  // Channel on after m pulses: value not yet reached, and never past the top
  function automatic logic [15:0] expOn(input int m);
    for (int n = 0; n < CHANNELS; n++)
      expOn[n] = (n == 15) ? (m < 4095) : (n >= m);
  endfunction

  // ==========================================================================
  // Scenarios
  task automatic testTrim();
    loadGray(GRAY_MID);
    u_lgpdt_ctrl_model.setMode(1'b1);
    u_lgpdt_ctrl_model.setBlank(1'b0);
    u_lgpdt_ctrl_model.sendBits(lgpdt_shift_t'(TRIM_VAL), TRIM_LEN);
    u_lgpdt_ctrl_model.strobe();
    tick(10);
    check("trim", currentTrim, TRIM_VAL);
    u_lgpdt_ctrl_model.setBlank(1'b1);
    u_lgpdt_ctrl_model.setMode(1'b0);
    loadGray(GRAY_MID);
    u_lgpdt_ctrl_model.extraPulse();
  endtask

  // Open flags and overtemp on the error pin, then read back the status
  task automatic testStatus();
    openLed = OPEN_PAT;
    u_lgpdt_ctrl_model.setBlank(1'b0);
    u_lgpdt_ctrl_model.pwmPulses(3);
    tick(310);
    check("err open", errorOutEn, 1'b1);
    u_lgpdt_ctrl_model.setBlank(1'b1);
    tick(10);
    check("err masked", errorOutEn, 1'b0);
    overTemp = 1'b1;
    tick(10);
    check("err temp", errorOutEn, 1'b1);
    u_lgpdt_ctrl_model.setBlank(1'b0);
    u_lgpdt_ctrl_model.pwmPulses(3);
    tick(30);
    loadGray(GRAY_MID);
    loadGray(GRAY_MID);
    u_lgpdt_ctrl_model.sendBits(GRAY_MID, GRAY_LEN);
    check("stat open", u_lgpdt_ctrl_model.rdBack[15:0], OPEN_PAT);
    check("stat temp", u_lgpdt_ctrl_model.rdBack[16], 1'b1);
    check("stat trim", u_lgpdt_ctrl_model.rdBack[119:24], TRIM_VAL);
  endtask

  // Counter walk: switch-on, switch-off, blank reset and stop at the top
  task automatic testPwm();
    int steps[9] = '{1, 1, 3, 10, 1, -1, 1, 4093, 4};
    u_lgpdt_ctrl_model.setBlank(1'b1);
    openLed = '0;
    overTemp = 1'b0;
    loadGray(pwmGray());
    check("blanked", sinkChannel, 16'h0000);
    u_lgpdt_ctrl_model.setBlank(1'b0);
    tick(10);
    check("no pulse", sinkChannel, 16'h0000);
    pulses = 0;
    foreach (steps[i])
    begin
      if (steps[i] < 0)
      begin
        u_lgpdt_ctrl_model.setBlank(1'b1);
        tick(10);
        check("reblank", sinkChannel, 16'h0000);
        u_lgpdt_ctrl_model.setBlank(1'b0);
        pulses = 0;
      end
      else
      begin
        u_lgpdt_ctrl_model.pwmPulses(steps[i]);
        pulses += steps[i];
        tick(10);
        check("sinks", sinkChannel, expOn(pulses));
      end
    end
    u_lgpdt_ctrl_model.setBlank(1'b1);
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    openLed = '0;
    overTemp = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    tick(3);
    rst = 1'b0;
    tick(2);
    check("rst sinks", sinkChannel, 16'h0000);
    check("rst err", errorOutEn, 1'b0);
    check("err level", errorOut_n, 1'b0);
    tick(10);
    testTrim();
    testStatus();
    testPwm();
    results();
  end

  initial
  begin
    #450000;
    fail_count++;
    results();
  end
endmodule

// File: sim/lgpdt_ctrl_model.sv
/*
  Controller model for the serial link: data, shift clock, strobe, mode,
  blank and the PWM counter clock. Assumes the core samples every pin.
*/
`timescale 1ns/100ps
module lgpdt_ctrl_model
  import lgpdt_pkg::*;
(
  // Status return
  input  wire logic serialOut,
  // Link pins
  output logic      serialIn,
  output logic      shiftClk,
  output logic      latchStrobe,
  output logic      modeSel,
  output logic      blank,
  output logic      pwmCountClk
);
  lgpdt_shift_t rdBack;

  // ==========================================================================
  // Idle levels: clocks stand still, sinks blanked until the first gray load is done
  initial
  begin
    serialIn    = 1'b0;
    shiftClk    = 1'b0;
    latchStrobe = 1'b0;
    modeSel     = 1'b0;
    blank       = 1'b1;
    pwmCountClk = 1'b0;
  end

  // ==========================================================================
  // Shift n bits MSB first, 64 ns a bit, sampling the chained output
  task automatic sendBits(input lgpdt_shift_t d, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      serialIn = d[i];
      #31;
      rdBack[i] = serialOut;
      #1 shiftClk = 1'b1;
      #32 shiftClk = 1'b0;
    end
    serialIn = ~serialIn; // Released line must not show a stale level
  endtask

  // Level latch: clock and data stay frozen while the strobe is high
  task automatic strobe();
    #32 latchStrobe = 1'b1;
    #50 latchStrobe = 1'b0;
    #50;
  endtask

  // One spare shift pulse after the first gray load following a trim load
  task automatic extraPulse();
    #32 shiftClk = 1'b1;
    #32 shiftClk = 1'b0;
  endtask

  // Mode flips only with the strobe low
  task automatic setMode(input logic m);
    #32 modeSel = m;
    #50;
  endtask

  // Blank pin; gray data is normally latched while it is high
  task automatic setBlank(input logic b);
    #32 blank = b;
    #50;
  endtask

  // PWM counter pulses, 30 ns high and low, well above the sampling floor
  task automatic pwmPulses(input int n);
    repeat (n)
    begin
      #30 pwmCountClk = 1'b1;
      #30 pwmCountClk = 1'b0;
    end
  endtask
endmodule
